// File: include/line_ctrl_pkg.sv
// constants and state types for the line interface control register
package line_ctrl_pkg;

  // register map
  localparam logic [7:0] CTRL_TWO_ADDR   = 8'h11;
  localparam logic [7:0] CTRL_TWO_RESET  = 8'h00;
  localparam logic [7:0] READ_IDLE_VALUE = 8'h00;

  // bit positions inside the control register
  localparam int CAL_CLEAR_BIT   = 7;
  localparam int MAN_CAL_BIT     = 6;
  localparam int AUTO_CAL_DIS_BIT = 5;
  localparam int RING_SEL_B_BIT  = 4;
  localparam int OVL_PROT_BIT    = 3;
  localparam int BILL_EN_BIT     = 2;
  localparam int RX_OVL_BIT      = 1;
  localparam int BILL_DET_BIT    = 0;

  // event indices inside the flag unit
  localparam int EV_RX_OVL  = 0;
  localparam int EV_BILLING = 1;
  localparam int EV_COUNT   = 2;

  // writable control bits, strobes and read data, held in the main module
  typedef struct packed {
    logic       cal_clear_q;
    logic       man_cal_q;
    logic       auto_cal_dis_q;
    logic       ring_sel_b_q;
    logic       ovl_prot_q;
    logic       bill_en_q;
    logic       man_cal_pulse_q;
    logic       irq_clear_pulse_q;
    logic [7:0] rdata_q;
  } ctrl_state_type;

  // synchroniser and sticky flag state of the flag unit
  typedef struct packed {
    logic [EV_COUNT-1:0] sync1_q;
    logic [EV_COUNT-1:0] sync2_q;
    logic [EV_COUNT-1:0] flag_q;
  } flag_state_type;

endpackage : line_ctrl_pkg

// File: include/event_flag_if.sv
// carrier between the control register and its sticky flag unit
`timescale 1ns/100ps
`default_nettype none

interface event_flag_if;
  import line_ctrl_pkg::*;
  logic [EV_COUNT-1:0] clear;  // one-cycle clear requests
  logic [EV_COUNT-1:0] arm;    // level: event may set its flag
  logic [EV_COUNT-1:0] flag;   // sticky flags

  modport owner (output clear, output arm, input flag);
  modport unit  (input clear, input arm, output flag);
endinterface : event_flag_if

`default_nettype wire

// File: core/event_flag_unit.sv
// synchronises analog event levels and keeps the sticky status flags
`timescale 1ns/100ps
`default_nettype none

module event_flag_unit
  import line_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          arst_n,
  // raw event levels from the analog front end
  input  wire logic [EV_COUNT-1:0] event_raw,
  // flags toward the register
  event_flag_if.unit         flags
);

  flag_state_type state_q;
  flag_state_type state_d;

  // two-stage synchroniser, then set-dominant sticky flags
  always_comb begin
    state_d         = state_q;
    state_d.sync1_q = event_raw;
    state_d.sync2_q = state_q.sync1_q;
    for (int i = 0; i < EV_COUNT; i++) begin
      // set wins over clear so an event in the clear cycle is kept
      if (state_q.sync2_q[i] && flags.arm[i]) begin
        state_d.flag_q[i] = 1'b1;
      end else if (flags.clear[i]) begin
        state_d.flag_q[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flags.flag = state_q.flag_q;

endmodule : event_flag_unit

`default_nettype wire

// File: core/line_interface_control_reg.sv
// second line interface control register with calibration and event flags
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - calibration clear bit 7 high discards stored converter calibration data.
// - writing one to bit 6 starts a manual converter calibration.
// - bit 5 zero allows automatic calibration, one suppresses it.
// - bit 4 is the second ring threshold select, paired with select a.
// - billing enable bit 2 keeps the line off-hook through supply dips.
// - billing detected flag bit 0 sets on a line supply disruption.
// - writing billing enable to zero clears the billing detected flag.
// - receive overload flag bit 1 sets when receive input is excessive.
// - writing zero to bit 1 clears it and the overload interrupt flag.
module line_interface_control_reg
  import line_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // host control port, same clock domain
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // analog event levels, asynchronous
  input  wire logic       rx_below_ground,
  input  wire logic       line_supply_dip,
  // converter calibration control
  output logic            calibration_clear,
  output logic            manual_calibration_start,
  output logic            auto_calibration_enable,
  // line side control
  output logic            ring_threshold_select_b,
  output logic            overload_protect_enable,
  output logic            billing_tone_enable,
  // to the interrupt status register
  output logic            receive_overload_irq_clear,
  output logic            receive_overload_flag,
  output logic            billing_tone_detected
);

  ctrl_state_type state_q;
  ctrl_state_type state_d;
  logic           wr_hit;
  logic           rd_hit;
  logic     [7:0] rd_image;

  event_flag_if flags ();

  // address match, shared by the write and read paths
  function automatic logic addr_hit(input logic [7:0] addr);
    return addr == CTRL_TWO_ADDR;
  endfunction : addr_hit

  assign wr_hit = reg_wr && addr_hit(reg_addr);
  assign rd_hit = reg_rd && addr_hit(reg_addr);

  // clear requests and arming of the sticky flags; the flag unit gives a
  // set priority over a clear, so an event landing in the very cycle of a
  // clearing write is still reported on the next read
  always_comb begin
    flags.clear = '0;
    flags.arm   = '0;
    // overload is always armed; only a written zero clears it
    flags.arm[EV_RX_OVL]   = 1'b1;
    flags.clear[EV_RX_OVL] = wr_hit && !reg_wdata[RX_OVL_BIT];
    // billing flag only works while enabled; the stored enable is used,
    // so a disruption seen in the cycle that writes the enable to zero
    // still sets the flag, and software needs a second zero write
    flags.arm[EV_BILLING]   = state_q.bill_en_q;
    flags.clear[EV_BILLING] = wr_hit && !reg_wdata[BILL_EN_BIT];
  end

  // readback image, every field at its named position; the old contents
  // are shown, so a read in the cycle of a write returns the earlier value
  always_comb begin
    rd_image                   = '0;
    rd_image[CAL_CLEAR_BIT]    = state_q.cal_clear_q;
    rd_image[MAN_CAL_BIT]      = state_q.man_cal_q;
    rd_image[AUTO_CAL_DIS_BIT] = state_q.auto_cal_dis_q;
    rd_image[RING_SEL_B_BIT]   = state_q.ring_sel_b_q;
    rd_image[OVL_PROT_BIT]     = state_q.ovl_prot_q;
    rd_image[BILL_EN_BIT]      = state_q.bill_en_q;
    rd_image[RX_OVL_BIT]       = flags.flag[EV_RX_OVL];
    rd_image[BILL_DET_BIT]     = flags.flag[EV_BILLING];
  end

  // register writes, strobes and registered read data
  // calibration clear is a plain level: it stays asserted until software
  // writes the bit back to zero, the converter side sees no pulse
  always_comb begin
    state_d                   = state_q;
    state_d.man_cal_pulse_q   = 1'b0;
    state_d.irq_clear_pulse_q = 1'b0;
    if (wr_hit) begin
      state_d.cal_clear_q    = reg_wdata[CAL_CLEAR_BIT];
      state_d.man_cal_q      = reg_wdata[MAN_CAL_BIT];
      state_d.auto_cal_dis_q = reg_wdata[AUTO_CAL_DIS_BIT];
      state_d.ring_sel_b_q   = reg_wdata[RING_SEL_B_BIT];
      state_d.ovl_prot_q     = reg_wdata[OVL_PROT_BIT];
      state_d.bill_en_q      = reg_wdata[BILL_EN_BIT];
      // each write of one launches a fresh calibration
      state_d.man_cal_pulse_q = reg_wdata[MAN_CAL_BIT];
      // written zero also clears the interrupt-side overload flag
      state_d.irq_clear_pulse_q = !reg_wdata[RX_OVL_BIT];
      // the billing detected bit in the write data is ignored
    end
    // read data held until the next read
    if (rd_hit) begin
      state_d.rdata_q = rd_image;
    end else if (reg_rd) begin
      state_d.rdata_q = READ_IDLE_VALUE;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= '{cal_clear_q:       CTRL_TWO_RESET[CAL_CLEAR_BIT],
                   man_cal_q:         CTRL_TWO_RESET[MAN_CAL_BIT],
                   auto_cal_dis_q:    CTRL_TWO_RESET[AUTO_CAL_DIS_BIT],
                   ring_sel_b_q:      CTRL_TWO_RESET[RING_SEL_B_BIT],
                   ovl_prot_q:        CTRL_TWO_RESET[OVL_PROT_BIT],
                   bill_en_q:         CTRL_TWO_RESET[BILL_EN_BIT],
                   man_cal_pulse_q:   1'b0,
                   irq_clear_pulse_q: 1'b0,
                   rdata_q:           READ_IDLE_VALUE};
    end else begin
      state_q <= state_d;
    end
  end

  // sticky event flags; the analog levels are asynchronous and only reach
  // logic through the unit's two-flop synchronisers
  event_flag_unit event_flag_unit_i (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .event_raw ({line_supply_dip, rx_below_ground}),
    .flags     (flags)
  );

  // outputs, all straight from flip-flops so the analog side never sees a
  // decode glitch; the calibration pulse lasts exactly one clock
  assign reg_rdata                  = state_q.rdata_q;
  assign calibration_clear          = state_q.cal_clear_q;
  assign manual_calibration_start   = state_q.man_cal_pulse_q;
  assign auto_calibration_enable    = !state_q.auto_cal_dis_q;
  // reserved threshold pairs are software's to avoid; passed as written
  assign ring_threshold_select_b    = state_q.ring_sel_b_q;
  assign overload_protect_enable    = state_q.ovl_prot_q;
  assign billing_tone_enable        = state_q.bill_en_q;
  assign receive_overload_irq_clear = state_q.irq_clear_pulse_q;
  assign receive_overload_flag      = flags.flag[EV_RX_OVL];
  assign billing_tone_detected      = flags.flag[EV_BILLING];

endmodule : line_interface_control_reg

`default_nettype wire

// File: tb/line_interface_control_reg_props.sv
// assertion checker for the line interface control register
`timescale 1ns/100ps
`default_nettype none
module line_ctrl_props
  import line_ctrl_pkg::*;
(
  // clock, reset and host port
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  // events and outputs
  input wire logic       rx_below_ground,
  input wire logic       line_supply_dip,
  input wire logic       calibration_clear,
  input wire logic       manual_calibration_start,
  input wire logic       auto_calibration_enable,
  input wire logic       overload_protect_enable,
  input wire logic       billing_tone_enable,
  input wire logic       receive_overload_irq_clear,
  input wire logic       receive_overload_flag,
  input wire logic       billing_tone_detected
);
  // writes that hit the register, and the two pulse causes
  wire w  = reg_wr && reg_addr == CTRL_TWO_ADDR;
  wire mc = w && reg_wdata[MAN_CAL_BIT];
  wire ic = w && !reg_wdata[RX_OVL_BIT];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_cal_clear_bit:
    assert property (w |=> calibration_clear == $past(reg_wdata[7]))
    else $error("calibration clear does not follow write");
  a_man_cal_pulse:
    assert property (manual_calibration_start == $past(mc))
    else $error("manual calibration pulse wrong");
  a_auto_cal_inverse:
    assert property (w |=> auto_calibration_enable != $past(reg_wdata[5]))
    else $error("auto calibration enable not inverse of bit");
  a_overload_prot_bit:
    assert property (w |=> overload_protect_enable == $past(reg_wdata[3]))
    else $error("overload protect does not follow write");
  a_billing_en_bit:
    assert property (w |=> billing_tone_enable == $past(reg_wdata[2]))
    else $error("billing enable does not follow write");
  a_rx_ovl_set:
    assert property (rx_below_ground [*3] |=> receive_overload_flag)
    else $error("receive overload flag not set");
  a_rx_ovl_clear:
    assert property (!rx_below_ground [*3] ##0 ic |=> !receive_overload_flag)
    else $error("receive overload flag not cleared");
  a_irq_clear_pulse:
    assert property (receive_overload_irq_clear == $past(ic))
    else $error("interrupt clear pulse wrong");
  a_billing_det_set:
    assert property ((line_supply_dip && billing_tone_enable) [*3]
      |=> billing_tone_detected)
    else $error("billing detected flag not set");
  a_billing_det_clear:
    assert property (!line_supply_dip [*3] ##0 (w && !reg_wdata[2])
      |=> !billing_tone_detected)
    else $error("billing detected flag not cleared");
  // main scenarios reached
  c_man_cal: cover property (mc);
  c_ovl_clear: cover property (receive_overload_flag ##1 ic);
  c_billing: cover property (billing_tone_detected);
endmodule : line_ctrl_props
bind line_interface_control_reg line_ctrl_props line_ctrl_props_i (.*);
`default_nettype wire

// File: tb/line_interface_control_reg_test.sv
// self-checking bench for the line interface control register
`timescale 1ns/100ps
`default_nettype none
module line_interface_control_reg_test import line_ctrl_pkg::*;;
  logic ref_clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic rx_below_ground = 1'h0, line_supply_dip = 1'h0;
  logic calibration_clear, manual_calibration_start, auto_calibration_enable;
  logic ring_threshold_select_b, overload_protect_enable, billing_tone_enable;
  logic receive_overload_irq_clear, receive_overload_flag;
  logic billing_tone_detected;
  logic [7:0]  notes[$];
  logic [31:0] seed = 32'h8470;
  int          bad_count = 0;
  int          cmp_count = 0;

  line_interface_control_reg line_interface_control_reg_i (.*);

  // 200 MHz clock
  initial forever #2.5 ref_clk = ~ref_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic chk(input string n, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // strobes rise 1 ns after an edge and drop 1 ns after the taking edge
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(posedge ref_clk);
    #1 reg_wr = 1'h0;
    // the strobes stand for the one cycle after the taking edge
    chk("pulses", {6'h00, a == CTRL_TWO_ADDR && d[MAN_CAL_BIT],
      a == CTRL_TWO_ADDR && !d[RX_OVL_BIT]},
      {6'h00, manual_calibration_start, receive_overload_irq_clear});
  endtask : wr

  task automatic rd(input logic [7:0] a, e);
    @(posedge ref_clk);
    #1 reg_addr = a;
    reg_rd = 1'h1;
    notes.push_back(e);
    @(posedge ref_clk);
    #1 reg_rd = 1'h0;
  endtask : rd

  // hold event levels well past the two-flop synchroniser, then idle
  task automatic ev(input logic rx, dip);
    @(posedge ref_clk);
    #1 rx_below_ground = rx;
    line_supply_dip = dip;
    repeat (5) @(posedge ref_clk);
    #1 rx_below_ground = 1'h0;
    line_supply_dip = 1'h0;
    repeat (4) @(posedge ref_clk);
  endtask : ev

  // read data is registered, so look once the read edge has landed
  always @(posedge ref_clk) begin
    if (reg_rd === 1'h1) begin
      #2 chk("reg_rdata", notes.pop_front(), reg_rdata);
    end
  end

  task automatic conclude;
    if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  initial begin
    #20000;
    bad_count++;
    conclude;
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    #1 arst_n = 1'h1;
    chk("auto_en", 8'h01, {7'h00, auto_calibration_enable});
    rd(CTRL_TWO_ADDR, CTRL_TWO_RESET);
    // random writes; flag bits written as one must not set the flags
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      // select a lives elsewhere and is taken as one, so b may be one
      wr(CTRL_TWO_ADDR, seed[7:0]);
      chk("levels", {3'h0, seed[7], !seed[5], seed[4:2]},
        {3'h0, calibration_clear, auto_calibration_enable,
         ring_threshold_select_b, overload_protect_enable,
         billing_tone_enable});
      rd(CTRL_TWO_ADDR, {seed[7:2], 2'h0});
    end
    wr(8'h12, ~seed[7:0]);
    rd(CTRL_TWO_ADDR, {seed[7:2], 2'h0});
    rd(8'h12, READ_IDLE_VALUE);
    wr(CTRL_TWO_ADDR, 8'h00);
    // billing events ignored while disabled, overload always taken
    ev(1'h1, 1'h1);
    rd(CTRL_TWO_ADDR, 8'h02);
    wr(CTRL_TWO_ADDR, 8'h02);
    rd(CTRL_TWO_ADDR, 8'h02);
    wr(CTRL_TWO_ADDR, 8'h04);
    rd(CTRL_TWO_ADDR, 8'h04);
    ev(1'h0, 1'h1);
    rd(CTRL_TWO_ADDR, 8'h05);
    // a zero written to the detected bit itself must not clear it
    wr(CTRL_TWO_ADDR, 8'h04);
    rd(CTRL_TWO_ADDR, 8'h05);
    wr(CTRL_TWO_ADDR, 8'h00);
    rd(CTRL_TWO_ADDR, 8'h00);
    repeat (2) @(posedge ref_clk);
    conclude;
  end
endmodule : line_interface_control_reg_test
`default_nettype wire
